// ==== src/psmc_ctrl.sv ====
`timescale 1ns/100ps
// Notes on behaviour
// - power save instruction enters sleep or idle
// - sleep stops system clock and execution
// - idle stops cpu, system clock runs
// - wake on interrupt, watchdog timeout, reset
// - clock fail monitor off in sleep
// - sleep keeps rc osc if watchdog on
// - clear watchdog just before sleep if watchdog on
// - clear watchdog on idle entry
// - system clocked peripherals stop in sleep
// - sleep wake resumes previous clock source
// - regulator keep bits select sleep standby
// - idle keeps rc osc for watchdog/monitor
// - idle wake resumes after 2-4 cycles
// - per-peripheral stop in idle bit; here only timer1 has one (timerHalt)
// - coincident interrupt waits until entry done
// - doze divides only cpu clock
// - doze active while enable bit set
// - three bit ratio, 1:1 to 1:128
// - return on interrupt ends doze
// - new oscillator write unless locked
module psmc_ctrl (
	input wire logic clock,
	input wire logic rst,
	input wire logic [psmc_pkg::ADDR_W-1:0] addr,
	input wire logic [psmc_pkg::DATA_W-1:0] wrData,
	input wire logic wrStrobe,
	input wire logic rdStrobe,
	output logic [psmc_pkg::DATA_W-1:0] rdData,
	input wire logic powerSaveInstr,
	input wire logic powerSaveMode,
	input wire logic irqPending,
	input wire logic wdtTimeout,
	input wire logic wdtEnabled,
	input wire logic fscmEnabled,
	input wire logic clkCfgLocked,
	input wire logic [2:0] activeOscSel,
	output logic cpuClkEn,
	output logic irqServiceEn,
	output logic sysOscRun,
	output logic periphClkEn,
	output logic periphIdle,
	output logic timerHalt,
	output logic fscmActive,
	output logic lprcRun,
	output logic wdtClear,
	output logic coreRegStandby,
	output logic flashRegStandby,
	output logic dozeActive,
	output logic [2:0] newOscSelect,
	output logic newOscReq,
	output logic [2:0] restartOscSel
);
	import psmc_pkg::*;

	// ----------------------------------------
	// registers and state
	// ----------------------------------------
	psmc_state_t state_reg; // controller state
	psmc_state_t state_next; // next state
	logic coreKeep_reg; // core regulator keep on
	logic flashKeep_reg; // flash regulator keep on
	logic roi_reg; // return on interrupt
	logic dozeEn_reg; // cpu slowdown enable
	logic [2:0] dozeRatio_reg; // doze ratio code
	logic [2:0] newOsc_reg; // requested oscillator
	logic newOscReq_reg; // request pulse
	logic timerStop_reg; // timer stop in halt
	logic [2:0] restartOsc_reg; // source kept over sleep
	logic [DATA_W-1:0] rdData_reg; // read answer
	logic inRun; // state decodes
	logic inSleep;
	logic inIdle;
	logic inWake;
	logic wakeEvent; // interrupt or time-out wake cause
	logic enterSleep; // instruction decodes
	logic enterIdle;
	logic dozeTick; // cpu enable from divider
	logic wakeLast; // last wake delay cycle
	logic roiExit; // interrupt ends doze
	logic wrClkDiv; // write decodes
	logic wrOsc;

	assign inRun = (state_reg == ST_RUN);
	assign inSleep = (state_reg == ST_SLEEP);
	assign inIdle = (state_reg == ST_IDLE);
	assign inWake = (state_reg == ST_WAKE);
	assign wrClkDiv = wrStrobe && (addr == OFF_CLK_DIV);
	assign wrOsc = wrStrobe && (addr == OFF_OSC_CTRL);

	// ----------------------------------------
	// power save state machine
	// ----------------------------------------
	// instruction only acts while the cpu runs
	assign enterSleep = inRun && powerSaveInstr
		&& (powerSaveMode == MODE_SLEEP);
	assign enterIdle = inRun && powerSaveInstr
		&& (powerSaveMode == MODE_IDLE);
	// interrupt or time-out is looked at in every cycle of the mode
	assign wakeEvent = irqPending || wdtTimeout;

	// next state
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_RUN: begin
				if (enterSleep) begin
					state_next = ST_SLEEP;
				end else if (enterIdle) begin
					state_next = ST_IDLE;
				end
			end
			ST_SLEEP, ST_IDLE: begin
				if (wakeEvent) begin
					state_next = ST_WAKE;
				end
			end
			ST_WAKE: begin
				if (wakeLast) begin
					state_next = ST_RUN;
				end
			end
			default: begin
				state_next = ST_RUN;
			end
		endcase
	end

	// state register; reset itself is a wake
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_reg <= ST_RUN;
		end else begin
			state_reg <= state_next;
		end
	end

	// delay before cpu clock is reapplied
	psmc_wake_timer #(
		.CYCLES(WAKE_CYC)
	) u_wake (
		.clock(clock),
		.rst(rst),
		.start((inSleep || inIdle) && wakeEvent),
		.last(wakeLast)
	);

	// ----------------------------------------
	// doze divider
	// ----------------------------------------
	assign dozeActive = dozeEn_reg;
	psmc_doze_div #(
		.RATIO_W(3)
	) u_doze (
		.clock(clock),
		.rst(rst),
		.dozeOn(dozeEn_reg),
		.ratio(dozeRatio_reg),
		.tick(dozeTick)
	);
	// interrupt brings back full speed
	assign roiExit = inRun && roi_reg && dozeEn_reg && irqPending;

	// ----------------------------------------
	// clock and power outputs
	// ----------------------------------------
	// cpu runs only in run state, at doze rate
	assign cpuClkEn = inRun && dozeTick;
	assign irqServiceEn = inRun;
	// system source off in sleep only
	assign sysOscRun = !inSleep;
	// peripheral clock never divided by doze
	assign periphClkEn = !inSleep;
	assign periphIdle = inIdle;
	assign timerHalt = inIdle && timerStop_reg;
	assign fscmActive = fscmEnabled && !inSleep;
	// rc oscillator need by mode
	always_comb begin
		if (inSleep) begin
			lprcRun = wdtEnabled;
		end else begin
			lprcRun = wdtEnabled || fscmEnabled;
		end
	end
	// watchdog clear in the entry cycle
	assign wdtClear = (enterSleep && wdtEnabled) || enterIdle;
	// standby unless the keep bit is set
	assign coreRegStandby = inSleep && !coreKeep_reg;
	assign flashRegStandby = inSleep && !flashKeep_reg;
	assign newOscSelect = newOsc_reg;
	assign newOscReq = newOscReq_reg;
	assign restartOscSel = restartOsc_reg;
	assign rdData = rdData_reg;

	// source held from sleep entry to wake
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			restartOsc_reg <= RST_NEW_OSC;
		end else if (inRun) begin
			restartOsc_reg <= activeOscSel;
		end
	end

	// ----------------------------------------
	// register writes
	// ----------------------------------------
	// reset control: regulator keep bits
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			coreKeep_reg <= RST_KEEP_ON;
			flashKeep_reg <= RST_KEEP_ON;
		end else if (wrStrobe && (addr == OFF_RESET_CTRL)) begin
			coreKeep_reg <= wrData[BIT_CORE_KEEP];
			flashKeep_reg <= wrData[BIT_FLASH_KEEP];
		end
	end

	// clock divider; a write beats the hardware clear
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			roi_reg <= RST_ROI;
			dozeEn_reg <= RST_DOZE_EN;
			dozeRatio_reg <= RST_DOZE_RATIO;
		end else if (wrClkDiv) begin
			roi_reg <= wrData[BIT_ROI];
			dozeEn_reg <= wrData[BIT_DOZE_EN];
			dozeRatio_reg <= wrData[POS_DOZE_RATIO +: 3];
		end else if (roiExit) begin
			dozeEn_reg <= 1'b0;
		end
	end

	// oscillator control, ignored when locked
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			newOsc_reg <= RST_NEW_OSC;
			newOscReq_reg <= 1'b0;
		end else begin
			newOscReq_reg <= wrOsc && !clkCfgLocked;
			if (wrOsc && !clkCfgLocked) begin
				newOsc_reg <= wrData[POS_NEW_OSC +: 3];
			end
		end
	end

	// timer control: stop in halt bit
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			timerStop_reg <= RST_TIMER_STOP;
		end else if (wrStrobe && (addr == OFF_TIMER1_CTRL)) begin
			timerStop_reg <= wrData[BIT_TIMER_STOP];
		end
	end

	// ----------------------------------------
	// register reads, one cycle later
	// ----------------------------------------
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rdData_reg <= '0;
		end else if (rdStrobe) begin
			rdData_reg <= '0;
			unique case (addr)
				OFF_RESET_CTRL: begin
					rdData_reg[BIT_CORE_KEEP] <= coreKeep_reg;
					rdData_reg[BIT_FLASH_KEEP] <= flashKeep_reg;
				end
				OFF_CLK_DIV: begin
					rdData_reg[BIT_ROI] <= roi_reg;
					rdData_reg[BIT_DOZE_EN] <= dozeEn_reg;
					rdData_reg[POS_DOZE_RATIO +: 3] <= dozeRatio_reg;
				end
				OFF_OSC_CTRL: begin
					rdData_reg[POS_NEW_OSC +: 3] <= newOsc_reg;
				end
				OFF_TIMER1_CTRL: begin
					rdData_reg[BIT_TIMER_STOP] <= timerStop_reg;
				end
				OFF_STATUS: begin
					rdData_reg[3:0] <= state_reg;
					rdData_reg[POS_STATUS_DOZE] <= dozeEn_reg;
				end
				default: begin
					rdData_reg <= '0; // unmapped reads zero
				end
			endcase
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	property p_enter;
		@(posedge clock) disable iff (rst)
		enterSleep |=> inSleep;
	endproperty
	a_enter: assert property (p_enter) else $error("no sleep entry");

	property p_sleep_clk;
		@(posedge clock) disable iff (rst)
		inSleep |-> !sysOscRun && !cpuClkEn && !periphClkEn;
	endproperty
	a_sleep_clk: assert property (p_sleep_clk) else $error("clock in sleep");

	property p_idle_clk;
		@(posedge clock) disable iff (rst)
		inIdle |-> sysOscRun && periphClkEn && !cpuClkEn;
	endproperty
	a_idle_clk: assert property (p_idle_clk) else $error("idle clocks");

	property p_wake;
		@(posedge clock) disable iff (rst)
		(inSleep || inIdle) && wdtTimeout |=> inWake;
	endproperty
	a_wake: assert property (p_wake) else $error("missed wake");

	property p_clock_fail_monitor;
		@(posedge clock) disable iff (rst)
		inSleep |-> !fscmActive && (lprcRun == wdtEnabled);
	endproperty
	a_clock_fail_monitor: assert property (p_clock_fail_monitor) else $error("sleep osc");

	property p_wdt_sleep;
		@(posedge clock) disable iff (rst)
		$rose(inSleep) && $past(wdtEnabled) |-> $past(wdtClear);
	endproperty
	a_wdt_sleep: assert property (p_wdt_sleep) else $error("wdt sleep");

	property p_wdt_idle;
		@(posedge clock) disable iff (rst)
		$rose(inIdle) |-> $past(wdtClear);
	endproperty
	a_wdt_idle: assert property (p_wdt_idle) else $error("wdt idle");

	property p_wake_time;
		@(posedge clock) disable iff (rst)
		$rose(inWake) |-> (!cpuClkEn)[*3] ##1 inRun;
	endproperty
	a_wake_time: assert property (p_wake_time) else $error("wake delay");

	property p_reg;
		@(posedge clock) disable iff (rst)
		inSleep |-> (coreRegStandby != coreKeep_reg)
			&& (flashRegStandby != flashKeep_reg);
	endproperty
	a_reg: assert property (p_reg) else $error("regulator");

	property p_roi;
		@(posedge clock) disable iff (rst)
		roiExit && !wrClkDiv |=> !dozeActive;
	endproperty
	a_roi: assert property (p_roi) else $error("roi exit");

	property p_lock;
		@(posedge clock) disable iff (rst)
		wrOsc && clkCfgLocked |=> $stable(newOscSelect) && !newOscReq;
	endproperty
	a_lock: assert property (p_lock) else $error("locked write");

	c_sleep: cover property (@(posedge clock) disable iff (rst)
		inSleep ##1 inWake);
	c_idle: cover property (@(posedge clock) disable iff (rst)
		inIdle ##1 inWake);
	c_roi: cover property (@(posedge clock) disable iff (rst) roiExit);
	c_doze: cover property (@(posedge clock) disable iff (rst)
		dozeActive && inRun && !cpuClkEn);
endmodule : psmc_ctrl

// ==== src/psmc_pkg.sv ====
package psmc_pkg;
	// ----------------------------------------
	// bus geometry
	// ----------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	// register offsets
	localparam logic [7:0] OFF_RESET_CTRL = 8'h00;
	localparam logic [7:0] OFF_CLK_DIV = 8'h04;
	localparam logic [7:0] OFF_OSC_CTRL = 8'h08;
	localparam logic [7:0] OFF_TIMER1_CTRL = 8'h0c;
	localparam logic [7:0] OFF_STATUS = 8'h10;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int BIT_CORE_KEEP = 8;
	localparam int BIT_FLASH_KEEP = 11;
	localparam int BIT_ROI = 15;
	localparam int BIT_DOZE_EN = 11;
	localparam int POS_DOZE_RATIO = 12;
	localparam int POS_NEW_OSC = 8;
	localparam int BIT_TIMER_STOP = 13;
	localparam int POS_STATUS_DOZE = 4;
	// reset values
	localparam logic RST_KEEP_ON = 1'b0;
	localparam logic RST_ROI = 1'b0;
	localparam logic RST_DOZE_EN = 1'b0;
	localparam logic [2:0] RST_DOZE_RATIO = 3'h0;
	localparam logic [2:0] RST_NEW_OSC = 3'h0;
	localparam logic RST_TIMER_STOP = 1'b0;
	// power save operand codes
	localparam logic MODE_SLEEP = 1'b0;
	localparam logic MODE_IDLE = 1'b1;
	// ----------------------------------------
	// timing, in clock cycles
	// ----------------------------------------
	localparam int WAKE_MIN_CYC = 2;
	localparam int WAKE_MAX_CYC = 4;
	localparam int WAKE_CYC = (WAKE_MIN_CYC + WAKE_MAX_CYC) / 2;
	// controller states
	typedef enum logic [3:0] {
		ST_RUN = 4'b0001,
		ST_SLEEP = 4'b0010,
		ST_IDLE = 4'b0100,
		ST_WAKE = 4'b1000
	} psmc_state_t;
endpackage : psmc_pkg

// ==== src/psmc_doze_div.sv ====
`timescale 1ns/100ps
module psmc_doze_div #(
	parameter int RATIO_W = 3
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic dozeOn,
	input wire logic [RATIO_W-1:0] ratio,
	output logic tick
);
	localparam int CNT_W = (1 << RATIO_W) - 1;
	logic [CNT_W-1:0] cnt_reg; // free count while dozing
	logic [CNT_W-1:0] mask; // low ratio bits set
	// ----------------------------------------
	// divisor mask, two to the power of ratio
	// ----------------------------------------
	always_comb begin
		for (int i = 0; i < CNT_W; i++) begin
			mask[i] = (i < int'(ratio));
		end
	end
	// counter restarts whenever doze is off
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cnt_reg <= '0;
		end else if (!dozeOn) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_reg + 1'b1;
		end
	end
	// full rate when off, else one pulse per period
	assign tick = !dozeOn || ((cnt_reg & mask) == mask);
endmodule : psmc_doze_div

// ==== src/psmc_wake_timer.sv ====
`timescale 1ns/100ps
module psmc_wake_timer #(
	parameter int CYCLES = 3
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic start,
	output logic last
);
	logic [3:0] cnt_reg; // cycles left
	// load on start, count down to zero
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cnt_reg <= 4'h0;
		end else if (start) begin
			cnt_reg <= 4'(CYCLES);
		end else if (cnt_reg != 4'h0) begin
			cnt_reg <= cnt_reg - 4'h1;
		end
	end
	// final cycle of the delay
	assign last = (cnt_reg == 4'h1);
endmodule : psmc_wake_timer

// ==== verif/psmc_core_model.sv ====
`timescale 1ns/100ps
module psmc_core_model (
	input wire logic clock,
	input wire logic rst,
	input wire logic saveReq,
	input wire logic saveMode,
	input wire logic irqReq,
	input wire logic wdtReq,
	input wire logic irqServiceEn,
	output logic powerSaveInstr,
	output logic powerSaveMode,
	output logic irqPending,
	output logic wdtTimeout
);
	// ----------------------------------------
	// instruction issue
	// ----------------------------------------
	// one cycle instruction; operand toggles when not qualified
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			powerSaveInstr <= 1'b0;
			powerSaveMode <= 1'b0;
		end else begin
			powerSaveInstr <= saveReq;
			powerSaveMode <= saveReq ? saveMode : ~powerSaveMode;
		end
	end
	// ----------------------------------------
	// interrupt and watchdog events
	// ----------------------------------------
	// pending until the cpu takes it, never during the instruction
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			irqPending <= 1'b0;
		end else if (irqReq) begin
			irqPending <= 1'b1;
		end else if (irqServiceEn && !powerSaveInstr) begin
			irqPending <= 1'b0;
		end
	end
	// one cycle time-out pulse
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wdtTimeout <= 1'b0;
		end else begin
			wdtTimeout <= wdtReq;
		end
	end
endmodule : psmc_core_model

// ==== verif/psmc_ctrl_test.sv ====
`timescale 1ns/100ps
module psmc_ctrl_test;
	import psmc_pkg::*;
	// ----------------------------------------
	// stimulus and observed signals
	// ----------------------------------------
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [15:0] wrData = 16'h0000;
	logic wrStrobe = 1'b0, rdStrobe = 1'b0;
	logic saveReq = 1'b0, saveMode = 1'b0;
	logic irqReq = 1'b0, wdtReq = 1'b0;
	logic wdtEnabled = 1'b0, fscmEnabled = 1'b0;
	logic clkCfgLocked = 1'b0;
	logic [2:0] activeOscSel = 3'h0;
	logic [15:0] rdData;
	logic powerSaveInstr, powerSaveMode, irqPending, wdtTimeout;
	logic cpuClkEn, irqServiceEn, sysOscRun, periphClkEn;
	logic periphIdle, timerHalt, fscmActive, lprcRun, wdtClear;
	logic coreRegStandby, flashRegStandby, dozeActive, newOscReq;
	logic [2:0] newOscSelect, restartOscSel;
	int numErrors = 0;
	int totalChecks = 0;
	// 100 MHz clock
	always #5 clock = ~clock;
	psmc_ctrl i_dut (.clock, .rst, .addr, .wrData, .wrStrobe,
		.rdStrobe, .rdData, .powerSaveInstr, .powerSaveMode,
		.irqPending, .wdtTimeout, .wdtEnabled, .fscmEnabled,
		.clkCfgLocked, .activeOscSel, .cpuClkEn, .irqServiceEn,
		.sysOscRun, .periphClkEn, .periphIdle, .timerHalt,
		.fscmActive, .lprcRun, .wdtClear, .coreRegStandby,
		.flashRegStandby, .dozeActive, .newOscSelect, .newOscReq,
		.restartOscSel);
	// far side: core and interrupt logic
	psmc_core_model i_core (.clock, .rst, .saveReq, .saveMode,
		.irqReq, .wdtReq, .irqServiceEn, .powerSaveInstr,
		.powerSaveMode, .irqPending, .wdtTimeout);
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	// verdict and end of run
	task automatic finishTest;
		$display("checks %0d errors %0d", totalChecks, numErrors);
		if (numErrors == 0 && totalChecks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : finishTest
	// compare one value
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		totalChecks++;
		if (got !== exp) begin
			numErrors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// one write cycle
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clock);
		addr <= a;
		wrData <= d;
		wrStrobe <= 1'b1;
		@(posedge clock);
		wrStrobe <= 1'b0;
	endtask : wr
	// one read cycle, data taken in the following cycle
	task automatic rdChk(input logic [7:0] a, input logic [15:0] e);
		@(posedge clock);
		addr <= a;
		rdStrobe <= 1'b1;
		@(posedge clock);
		rdStrobe <= 1'b0;
		#1;
		chk(rdData, e);
	endtask : rdChk
	// instruction, optionally with a coincident interrupt
	task automatic save(input logic m, input logic withIrq);
		@(posedge clock);
		saveReq <= 1'b1;
		saveMode <= m;
		irqReq <= withIrq;
		@(posedge clock);
		saveReq <= 1'b0;
		irqReq <= 1'b0;
		#1;
	endtask : save
	// one cycle wake event
	task automatic pulseEvt(input logic useWdt);
		@(posedge clock);
		irqReq <= !useWdt;
		wdtReq <= useWdt;
		@(posedge clock);
		irqReq <= 1'b0;
		wdtReq <= 1'b0;
	endtask : pulseEvt
	// count cycles with cpu clock held, bounded
	task automatic waitRun(output logic [15:0] n);
		n = 16'h0000;
		repeat (20) begin
			@(posedge clock);
			#1;
			if (cpuClkEn === 1'b1) break;
			n++;
		end
		if (n == 16'h0014) begin
			numErrors++;
			finishTest();
		end
	endtask : waitRun
	// count new oscillator request pulses over three cycles
	task automatic reqCount(output logic [15:0] n);
		n = 16'h0000;
		repeat (3) begin
			#1;
			n = n + {15'h0000, newOscReq};
			@(posedge clock);
		end
	endtask : reqCount
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	// reset values, unmapped read
	task automatic testReset;
		@(posedge clock);
		#1;
		chk(cpuClkEn, 1'b1);
		chk(sysOscRun, 1'b1);
		chk(irqServiceEn, 1'b1);
		rdChk(OFF_RESET_CTRL, 16'h0000);
		rdChk(OFF_CLK_DIV, 16'h0000);
		rdChk(OFF_OSC_CTRL, 16'h0000);
		rdChk(OFF_STATUS, 16'h0001);
		rdChk(8'h14, 16'h0000);
		$display("reset test done");
	endtask : testReset
	// sleep with watchdog on, wake by time-out
	task automatic testSleepWdt;
		logic [15:0] n;
		@(posedge clock);
		wdtEnabled <= 1'b1;
		fscmEnabled <= 1'b1;
		activeOscSel <= 3'h5;
		save(MODE_SLEEP, 1'b0);
		chk(wdtClear, 1'b1);
		@(posedge clock);
		activeOscSel <= 3'h2;
		#1;
		chk(sysOscRun, 1'b0);
		chk(cpuClkEn, 1'b0);
		chk(periphClkEn, 1'b0);
		chk(irqServiceEn, 1'b0);
		chk(fscmActive, 1'b0);
		chk(lprcRun, 1'b1);
		chk(coreRegStandby, 1'b1);
		chk(flashRegStandby, 1'b1);
		@(posedge clock);
		#1;
		chk(restartOscSel, 16'h0005);
		pulseEvt(1'b1);
		waitRun(n);
		chk(n, 16'(WAKE_CYC));
		$display("sleep watchdog test done");
	endtask : testSleepWdt
	// sleep with regulators kept on, watchdog off, wake by irq
	task automatic testSleepKeep;
		logic [15:0] n;
		wr(OFF_RESET_CTRL, 16'h0900);
		rdChk(OFF_RESET_CTRL, 16'h0900);
		@(posedge clock);
		wdtEnabled <= 1'b0;
		save(MODE_SLEEP, 1'b0);
		chk(wdtClear, 1'b0);
		@(posedge clock);
		#1;
		chk(coreRegStandby, 1'b0);
		chk(flashRegStandby, 1'b0);
		chk(lprcRun, 1'b0);
		pulseEvt(1'b0);
		waitRun(n);
		chk(n, 16'(WAKE_CYC));
		$display("sleep keep test done");
	endtask : testSleepKeep
	// idle with coincident interrupt and timer stop bit
	task automatic testIdle;
		logic [15:0] n;
		wr(OFF_TIMER1_CTRL, 16'h2000);
		rdChk(OFF_TIMER1_CTRL, 16'h2000);
		save(MODE_IDLE, 1'b1);
		chk(wdtClear, 1'b1);
		@(posedge clock);
		#1;
		chk(cpuClkEn, 1'b0);
		chk(sysOscRun, 1'b1);
		chk(periphClkEn, 1'b1);
		chk(periphIdle, 1'b1);
		chk(timerHalt, 1'b1);
		chk(lprcRun, 1'b1);
		chk(fscmActive, 1'b1);
		waitRun(n);
		chk(n, 16'(WAKE_CYC));
		$display("idle test done");
	endtask : testIdle
	// every doze ratio code
	task automatic testDoze;
		logic [15:0] cnt;
		for (int r = 0; r < 8; r++) begin
			wr(OFF_CLK_DIV, 16'h0800 | (16'(r) << 12));
			cnt = 16'h0000;
			repeat (256) begin
				@(posedge clock);
				#1;
				cnt = cnt + {15'h0000, cpuClkEn};
			end
			chk(cnt, 16'h0100 >> r);
			chk(periphClkEn, 1'b1);
			chk(dozeActive, 1'b1);
			rdChk(OFF_STATUS, 16'h0011);
			wr(OFF_CLK_DIV, 16'h0000);
		end
		$display("doze test done");
	endtask : testDoze
	// return on interrupt set and clear
	task automatic testRoi;
		wr(OFF_CLK_DIV, 16'ha800);
		pulseEvt(1'b0);
		@(posedge clock);
		#1;
		chk(dozeActive, 1'b0);
		rdChk(OFF_CLK_DIV, 16'ha000);
		wr(OFF_CLK_DIV, 16'h2800);
		pulseEvt(1'b0);
		@(posedge clock);
		#1;
		chk(dozeActive, 1'b1);
		wr(OFF_CLK_DIV, 16'h0000);
		$display("roi test done");
	endtask : testRoi
	// oscillator request unlocked, then locked
	task automatic testOsc;
		logic [15:0] n;
		wr(OFF_OSC_CTRL, 16'h0500);
		reqCount(n);
		chk(n, 16'h0001);
		chk(newOscSelect, 16'h0005);
		clkCfgLocked <= 1'b1;
		wr(OFF_OSC_CTRL, 16'h0300);
		reqCount(n);
		chk(n, 16'h0000);
		rdChk(OFF_OSC_CTRL, 16'h0500);
		@(posedge clock);
		clkCfgLocked <= 1'b0;
		$display("osc test done");
	endtask : testOsc
	// reset while idle brings the cpu straight back
	task automatic testResetWake;
		save(MODE_IDLE, 1'b0);
		@(posedge clock);
		#1;
		chk(periphIdle, 1'b1);
		@(posedge clock);
		rst <= 1'b1;
		#1;
		chk(cpuClkEn, 1'b1);
		chk(periphIdle, 1'b0);
		@(posedge clock);
		rst <= 1'b0;
		rdChk(OFF_STATUS, 16'h0001);
		rdChk(OFF_RESET_CTRL, 16'h0000);
		$display("reset wake test done");
	endtask : testResetWake
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		testReset();
		testSleepWdt();
		testSleepKeep();
		testIdle();
		testDoze();
		testRoi();
		testOsc();
		testResetWake();
		finishTest();
	end
	// hang guard
	initial begin
		#200000;
		numErrors++;
		finishTest();
	end
endmodule : psmc_ctrl_test
